// *** src/srs_pkg.sv ***
package srs_pkg;
    // timing
    localparam int SRS_CLK_HZ = 50_000_000;
    localparam int SRS_POR_DELAY_US = 100; // power_on_delay, plain default
    localparam int SRS_POR_CYCLES = SRS_POR_DELAY_US * (SRS_CLK_HZ / 1_000_000);
    localparam int SRS_CLK_MISS_NS = 1000; // longest gap between link clock edges
    localparam int SRS_CLK_MISS_CYCLES = SRS_CLK_MISS_NS / 20;
    localparam int SRS_CNT_W = 16;

    // register map (word offsets are byte addresses)
    localparam logic [7:0] SRS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SRS_ADDR_DIAG = 8'h04;
    localparam logic [7:0] SRS_ADDR_STAT = 8'h08;

    // control register fields
    localparam int SRS_CTRL_CLOCK_WATCHDOG_ENABLE = 0;
    // diagnosis register fields
    localparam int SRS_DIAG_RST = 0;
    localparam int SRS_DIAG_UV0 = 1;
    localparam int SRS_DIAG_UV1 = 2;
    localparam int SRS_DIAG_PUMP_UNDERVOLTAGE_FLAG = 3;
    localparam int SRS_DIAG_CPW = 4;
    localparam int SRS_DIAG_WDT = 5;

    localparam logic [31:0] SRS_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        SRS_SLEEP = 2'b00,
        SRS_HOLD = 2'b01,
        SRS_DELAY = 2'b10,
        SRS_RUN = 2'b11
    } srs_state_e;

    // raw comparator levels, high means supply is good
    typedef struct packed {
        logic logic_supply;
        logic analog_supply;
        logic reference_supply;
        logic [1:0] load_supply;
        logic pump_uv_ok;
        logic pump_warn_ok;
    } srs_cmp_s;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } srs_bus_s;
endpackage : srs_pkg

// *** src/srs_supervisor.sv ***
`timescale 1ns/1ns
// What this block does
// - hold internal reset while logic, analog or reference supply is low
// - with watchdog enabled, a missing or slow input clock holds reset
// - release only after supplies good and then the full power-on delay
// - serial access refused until the power-on delay is complete
// - set reset-occurred flag on every exit from reset
// - a diagnosis register access while running clears reset-occurred flag
// - low load supply disables only its channel and sets its flag
// - low pump voltage disables all outputs and sets pump-undervoltage flag
// - pump below warning level sets the pump-warning flag
// - between warning and undervoltage levels channels keep running
// - any of the three core supplies low enters sleep
// - sleep is left by itself once all three supplies recover
// - leaving sleep runs the same power-on delay as reset
// - delay count starts on the second clock after reset input rises
// - reset input low holds reset, fault low and serial port off
// - clock watchdog starts disabled on every exit from reset
module srs_supervisor
    import srs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host pins
    input wire logic external_reset_input,
    input wire logic link_clk_level,
    output logic fault_output,
    output logic fault_output_oe_n,
    // comparators
    input wire srs_pkg::srs_cmp_s cmp_raw,
    // register port
    input wire srs_pkg::srs_bus_s bus,
    output logic [31:0] rdata,
    // status to the rest of the device
    output logic internal_reset,
    output logic sleep_mode,
    output logic spi_enable,
    output logic [1:0] channel_enable
);
    import srs_pkg::*;


    // comparator levels after the first and second synchroniser stage
    srs_cmp_s sync1;
    srs_cmp_s cmp;

    // registered reset pin and link clock samples
    logic external_reset_input_q;
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_s3;

    // clock watchdog
    logic [SRS_CNT_W-1:0] miss_cnt;
    logic clock_lost;
    logic clock_watchdog_enable;

    // sequencer
    logic [SRS_CNT_W-1:0] por_cnt;
    srs_state_e state;
    srs_state_e next_state;

    // diagnosis flags
    logic reset_flag;
    logic [1:0] load_undervoltage_flag;
    logic pump_undervoltage_flag;
    logic pump_warning_flag;
    logic wd_fault;

    // decoded conditions
    logic supplies_ok;
    logic running;
    logic diag_hit;

    // two-stage synchronisers; first stage is read only by the second
    // the comparators switch with no relation to clk, so a level caught
    // mid-transition may go metastable; the second stage gives it a cycle
    // to settle, which costs one more cycle of reaction time on every supply
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            cmp <= '0;
        end else begin
            sync1 <= cmp_raw;
            cmp <= sync1;
        end
    end

    // reset input sampled as synchronous; sequencer reads the level of its registered copy
    // one register keeps the sequencer from seeing two values of the pin
    // within one cycle; the delay count begins one edge after this copy
    // goes high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            external_reset_input_q <= 1'b0;
        end else begin
            external_reset_input_q <= external_reset_input;
        end
    end

    // link clock sampled; third stage gives a clean edge detect
    // all stages reset low, the idle level of the pin, so no false rising
    // edge follows reset; the pin clock must stay well below half of clk
    // or edges are lost and the watchdog may trip on a running clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
        end else begin
            lclk_s1 <= link_clk_level;
            lclk_s2 <= lclk_s1;
            lclk_s3 <= lclk_s2;
        end
    end

    // core supply summary and bus decode; a diagnosis access counts only
    // while running, since the serial port is refused in every other state
    // and a refused access must leave the flags alone
    assign supplies_ok = cmp.logic_supply & cmp.analog_supply & cmp.reference_supply;
    assign running = (state == SRS_RUN);
    assign diag_hit = (bus.rd | bus.wr) && (bus.addr == SRS_ADDR_DIAG) && running;

    // gap counter between rising edges of the link clock
    // the counter stops at the limit instead of wrapping, so a clock that
    // stays away for a long time keeps the lost flag up until an edge
    // returns; a slow clock trips it just like a missing one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            miss_cnt <= '0;
            clock_lost <= 1'b0;
        end else if (lclk_s2 && !lclk_s3) begin
            miss_cnt <= '0;
            clock_lost <= 1'b0;
        end else if (miss_cnt >= SRS_CNT_W'(SRS_CLK_MISS_CYCLES)) begin
            clock_lost <= 1'b1;
        end else begin
            miss_cnt <= miss_cnt + 1'b1;
        end
    end

    // sequencer: sleep, held reset, power-on delay, running
    // the supply check overrides every state so that a dip at any moment
    // falls back to sleep; the pin check comes second, as a low pin while
    // asleep changes nothing; a watchdog trip lands in the held state, which
    // the high pin leaves for a new delay; the latched fault sends each run entry back
    always_comb begin
        next_state = state;
        case (state)
            SRS_SLEEP: begin
                if (supplies_ok) begin
                    next_state = SRS_HOLD;
                end
            end
            SRS_HOLD: begin
                if (external_reset_input_q) begin
                    next_state = SRS_DELAY;
                end
            end
            SRS_DELAY: begin
                if (por_cnt >= SRS_CNT_W'(SRS_POR_CYCLES - 1)) begin
                    next_state = SRS_RUN;
                end
            end
            SRS_RUN: begin
                if (wd_fault) begin
                    next_state = SRS_HOLD;
                end
            end
            default: next_state = SRS_SLEEP;
        endcase
        if (!supplies_ok) begin
            next_state = SRS_SLEEP;
        end else if (!external_reset_input_q && state != SRS_SLEEP) begin
            next_state = SRS_HOLD;
        end
    end

    // state register; the block comes out of reset asleep and only
    // reaches the running state through the full delay, never by a
    // shortcut from sleep or from the held state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SRS_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // power-on delay counter; restarts on each entry, also after sleep
    // clearing outside the delay state means a supply glitch or pin pulse
    // in mid-count starts the whole delay again rather than resuming it
    // the compare stops one short because the state change adds an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt <= '0;
        end else if (state == SRS_DELAY) begin
            por_cnt <= por_cnt + 1'b1;
        end else begin
            por_cnt <= '0;
        end
    end

    // watchdog fault is latched until an external or power-on reset
    // a returning clock alone must not release the device, otherwise an
    // intermittent clock would let it run in bursts; the latch is only
    // armed while running with the watchdog enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_fault <= 1'b0;
        end else if (state == SRS_SLEEP || !external_reset_input_q) begin
            wd_fault <= 1'b0;
        end else if (clock_watchdog_enable && clock_lost && running) begin
            wd_fault <= 1'b1;
        end
    end

    // watchdog enable, writable only while running
    // the enable drops on every exit from the running state, so after any
    // reset the host has to arm it again; a host that forgets leaves the
    // device without clock supervision
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_watchdog_enable <= 1'b0;
        end else if (!running) begin
            clock_watchdog_enable <= 1'b0;
        end else if (bus.wr && bus.addr == SRS_ADDR_CTRL) begin
            clock_watchdog_enable <= bus.wdata[SRS_CTRL_CLOCK_WATCHDOG_ENABLE];
        end
    end

    // reset-occurred flag; the exit event wins over an access clear
    // it is set on the same edge that enters the running state, so the
    // first diagnosis read after any reset or sleep sees it exactly once
    // the flag survives a later reset and is set again on the next exit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_flag <= 1'b0;
        end else if (state == SRS_DELAY && next_state == SRS_RUN) begin
            reset_flag <= 1'b1;
        end else if (diag_hit) begin
            reset_flag <= 1'b0;
        end
    end

    // load and pump flags, sticky until a diagnosis access
    // an access clears a flag only if its condition has gone; while the
    // fault persists the set term wins, so the host can never read a
    // false all-clear; flags are meaningless and held clear when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_undervoltage_flag <= '0;
            pump_undervoltage_flag <= 1'b0;
            pump_warning_flag <= 1'b0;
        end else if (!running) begin
            load_undervoltage_flag <= '0;
            pump_undervoltage_flag <= 1'b0;
            pump_warning_flag <= 1'b0;
        end else begin
            load_undervoltage_flag <= ~cmp.load_supply
                | (diag_hit ? 2'b00 : load_undervoltage_flag);
            pump_undervoltage_flag <= !cmp.pump_uv_ok
                | (!diag_hit & pump_undervoltage_flag);
            pump_warning_flag <= !cmp.pump_warn_ok
                | (!diag_hit & pump_warning_flag);
        end
    end

    // output stages: per-channel load gate, common pump gate
    // a low load supply cuts only its own channel, a low pump cuts both
    // since they share one pump; the enables follow the synchronised
    // levels directly, so a recovered supply turns its stage back on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_enable <= '0;
        end else begin
            // warning level alone never gates the channels
            channel_enable <= (running && cmp.pump_uv_ok) ? cmp.load_supply : 2'b00;
        end
    end

    // status outputs, all from flip-flops
    // they are decoded from the next state so that each output changes on
    // the same edge as the state register instead of one cycle behind it;
    // the fault pin is open drain, driven low by a low output enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_reset <= 1'b1;
            sleep_mode <= 1'b1;
            spi_enable <= 1'b0;
            fault_output <= 1'b0;
            fault_output_oe_n <= 1'b0;
        end else begin
            internal_reset <= (next_state != SRS_RUN);
            sleep_mode <= (next_state == SRS_SLEEP);
            spi_enable <= (next_state == SRS_RUN);
            fault_output <= 1'b0; // open drain: only ever pulls low
            // released only when running and free of supply faults
            fault_output_oe_n <= !((next_state != SRS_RUN) || wd_fault
                || !cmp.pump_uv_ok || (cmp.load_supply != 2'b11));
        end
    end

    // read port; refused while not running, unmapped reads zero
    // data stand for one cycle only and drop back to zero, so a master
    // that samples late reads zero rather than stale data; reading the
    // diagnosis register is itself an access and clears what it returns except the watchdog fault and any flag whose condition persists
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= SRS_ZERO;
        end else if (bus.rd && running) begin
            if (bus.addr == SRS_ADDR_CTRL) begin
                rdata <= {31'h0000_0000, clock_watchdog_enable};
            end else if (bus.addr == SRS_ADDR_DIAG) begin
                rdata <= {26'h000_0000, wd_fault, pump_warning_flag,
                    pump_undervoltage_flag, load_undervoltage_flag, reset_flag};
            end else if (bus.addr == SRS_ADDR_STAT) begin
                rdata <= {30'h0000_0000, state};
            end else begin
                rdata <= SRS_ZERO;
            end
        end else begin
            rdata <= SRS_ZERO;
        end
    end
endmodule : srs_supervisor

// *** test/srs_host_model.sv ***
`timescale 1ns/1ns
module srs_host_model (
    // bench control
    input wire logic clk,
    input wire logic hold_reset,
    input wire logic clk_run,
    // pins toward the device
    output logic external_reset_input,
    output logic link_clk_level
);
    initial external_reset_input = 1'b0;
    initial link_clk_level = 1'b0;
    // reset pin follows the host's wish one cycle late, low holds the device
    always @(posedge clk) begin
        external_reset_input <= !hold_reset;
    end
    // pin clock slower than clk so every edge is seen; stands still when stopped
    always #60 if (clk_run) link_clk_level = !link_clk_level;
endmodule : srs_host_model

// *** test/srs_supervisor_props.sv ***
`timescale 1ns/1ns
module srs_supervisor_props
    import srs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic external_reset_input,
    input wire srs_pkg::srs_cmp_s cmp_raw,
    input wire srs_pkg::srs_bus_s bus,
    input wire logic [31:0] rdata,
    input wire logic fault_output_oe_n,
    input wire logic internal_reset,
    input wire logic sleep_mode,
    input wire logic spi_enable,
    input wire logic [1:0] channel_enable
);
    logic core_ok, spi_q, rst_pend, pend_now, diag_rd;
    logic [SRS_CNT_W-1:0] good_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // reference view of the reset flag; a set on run entry beats a clearing access
    assign core_ok = cmp_raw.logic_supply & cmp_raw.analog_supply & cmp_raw.reference_supply;
    assign diag_rd = spi_enable & bus.rd & (bus.addr == SRS_ADDR_DIAG);
    assign pend_now = rst_pend | (spi_enable & ~spi_q);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_q <= 1'b0;
            rst_pend <= 1'b0;
        end else begin
            spi_q <= spi_enable;
            rst_pend <= (rst_pend & ~(diag_rd | (spi_enable & bus.wr &
                (bus.addr == SRS_ADDR_DIAG)))) | (spi_enable & ~spi_q);
        end
    end
    // cycles with good supplies and released pin; saturates so long runs stay sane
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            good_cnt <= '0;
        end else if (!core_ok || !external_reset_input) begin
            good_cnt <= '0;
        end else if (good_cnt != '1) begin
            good_cnt <= good_cnt + 1'b1;
        end
    end

    AST_CORE_SLEEP: assert property ((!core_ok) [*5] |-> sleep_mode && internal_reset)
        else $error("core supply low but still awake");
    AST_POR_DELAY: assert property ($rose(spi_enable) |->
        good_cnt >= SRS_POR_CYCLES && good_cnt <= SRS_POR_CYCLES + 12)
        else $error("run entered outside power-on delay");
    AST_PIN_HOLD: assert property ((!external_reset_input) [*4] |->
        internal_reset && !spi_enable && !fault_output_oe_n) else $error("pin reset ignored");
    AST_SPI_RUN: assert property ($rose(spi_enable) |-> $fell(internal_reset))
        else $error("serial port and reset disagree");
    AST_READ_ZERO: assert property (!(bus.rd && spi_enable) |=> rdata == SRS_ZERO)
        else $error("read data without accepted read");
    AST_RST_FLAG: assert property (diag_rd |=> rdata[SRS_DIAG_RST] == $past(pend_now))
        else $error("reset flag wrong");
    AST_LOAD_CUT: assert property ($stable(cmp_raw.load_supply) [*5] |->
        (channel_enable & ~cmp_raw.load_supply) == 2'b00) else $error("channel on at low load");
    AST_PUMP_CUT: assert property ((!cmp_raw.pump_uv_ok) [*5] |-> channel_enable == 2'b00)
        else $error("channel on at low pump");
    AST_PUMP_WARN: assert property ((!cmp_raw.pump_warn_ok) [*5] ##0 diag_rd |=>
        rdata[SRS_DIAG_CPW]) else $error("pump warning missing");
endmodule : srs_supervisor_props

bind srs_supervisor srs_supervisor_props u_props (.clk(clk), .rst_n(rst_n),
    .external_reset_input(external_reset_input), .cmp_raw(cmp_raw), .bus(bus), .rdata(rdata),
    .fault_output_oe_n(fault_output_oe_n), .internal_reset(internal_reset),
    .sleep_mode(sleep_mode), .spi_enable(spi_enable), .channel_enable(channel_enable));

// *** test/tb_supply_reset_supervisor.sv ***
`timescale 1ns/1ns
module tb_supply_reset_supervisor;
    import srs_pkg::*;
    logic clk, rst_n, hold_reset, clk_run, external_reset_input, link_clk_level;
    logic fault_output, fault_output_oe_n, internal_reset, sleep_mode, spi_enable, rd_seen;
    logic [1:0] channel_enable, uv, ce;
    logic [31:0] rdata, d;
    logic [31:0] exp_q[$];
    srs_cmp_s cmp;
    srs_bus_s bus;
    int fail_count, n_compared, seed;

    always #10 clk = ~clk;
    srs_supervisor dut (.clk(clk), .rst_n(rst_n), .external_reset_input(external_reset_input),
        .link_clk_level(link_clk_level), .fault_output(fault_output),
        .fault_output_oe_n(fault_output_oe_n),
        .cmp_raw(cmp), .bus(bus), .rdata(rdata), .internal_reset(internal_reset),
        .sleep_mode(sleep_mode), .spi_enable(spi_enable), .channel_enable(channel_enable));
    srs_host_model host (.clk(clk), .hold_reset(hold_reset), .clk_run(clk_run),
        .external_reset_input(external_reset_input), .link_clk_level(link_clk_level));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one bus cycle; a read notes its expected data for the monitor
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dat,
        input logic [31:0] e);
        bus <= '{addr: a, wdata: dat, wr: w, rd: !w};
        if (!w) exp_q.push_back(e);
        @(posedge clk);
    endtask : acc
    task automatic idle(input int n);
        bus <= '0;
        repeat (n) @(posedge clk);
    endtask : idle
    // host waits for the serial port before any access, bounded
    task automatic run_up();
        int n;
        n = 0;
        while (spi_enable !== 1'b1 && n < 6000) begin
            @(posedge clk);
            n++;
        end
        chk("delay", 32'(n >= SRS_POR_CYCLES && n <= SRS_POR_CYCLES + 12), 32'h1);
    endtask : run_up
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // read data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= bus.rd;
    always @(negedge clk) begin
        if (rd_seen) chk("rdata", rdata, exp_q.pop_front());
    end
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    initial begin
        seed = 77143;
        clk = 1'b0;
        rst_n = 1'b0;
        hold_reset = 1'b1;
        clk_run = 1'b1;
        cmp = '1;
        bus = '0;
        uv = 2'b00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        idle(5);
        chk("oe_n", 32'(fault_output_oe_n), 32'h0);
        acc(0, SRS_ADDR_DIAG, 0, 32'h0);
        hold_reset <= 1'b0;
        idle(1);
        run_up();
        chk("oe_n run", 32'(fault_output_oe_n), 32'h1);
        chk("fault data", 32'(fault_output), 32'h0);
        d = $random(seed);
        acc(0, SRS_ADDR_DIAG, 0, 32'h1);
        acc(0, SRS_ADDR_DIAG, 0, 32'h0);
        acc(0, SRS_ADDR_STAT, 0, 32'h3);
        acc(0, 8'h0c, 0, 32'h0);
        acc(1, SRS_ADDR_CTRL, d, 0);
        acc(0, SRS_ADDR_CTRL, 0, {31'h0, d[0]});
        for (int i = 0; i < 3; i++) begin
            cmp.load_supply <= 2'($random(seed));
            idle(8);
            uv = uv | ~cmp.load_supply;
            chk("chan", 32'(channel_enable & ~cmp.load_supply), 32'h0);
        end
        cmp.load_supply <= 2'b11;
        idle(6);
        acc(0, SRS_ADDR_DIAG, 0, 32'(uv) << 1);
        ce = channel_enable;
        cmp.pump_warn_ok <= 1'b0;
        idle(8);
        chk("warn chan", 32'(channel_enable), 32'(ce));
        acc(0, SRS_ADDR_DIAG, 0, 32'h10);
        cmp.pump_uv_ok <= 1'b0;
        idle(8);
        chk("pump chan", 32'(channel_enable), 32'h0);
        acc(0, SRS_ADDR_DIAG, 0, 32'h18);
        cmp <= '1;
        idle(6);
        acc(0, SRS_ADDR_DIAG, 0, 32'h18);
        acc(0, SRS_ADDR_DIAG, 0, 32'h0);
        acc(1, SRS_ADDR_CTRL, 32'h1, 0);
        clk_run <= 1'b0;
        idle(100);
        chk("wd reset", 32'({internal_reset, fault_output_oe_n}), 32'h2);
        clk_run <= 1'b1;
        hold_reset <= 1'b1;
        idle(6);
        hold_reset <= 1'b0;
        run_up();
        acc(0, SRS_ADDR_CTRL, 0, 32'h0);
        acc(0, SRS_ADDR_DIAG, 0, 32'h1);
        cmp.analog_supply <= 1'b0;
        idle(8);
        chk("sleep", 32'({sleep_mode, internal_reset}), 32'h3);
        cmp.analog_supply <= 1'b1;
        run_up();
        acc(0, SRS_ADDR_DIAG, 0, 32'h1);
        idle(3);
        give_verdict();
    end
endmodule : tb_supply_reset_supervisor
